// ==== include/dtc_pkg.sv ====
package dtc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam int unsigned IDX_LSB = 2;
	localparam logic [7:0] IDX_TIMER_IRQ_CTL = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE_CTL = 8'h89;
	localparam logic [7:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
	localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h8b;
	localparam logic [7:0] IDX_TIMER0_COUNT_HIGH = 8'h8c;
	localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
	localparam logic [7:0] IDX_CLOCK_DIVIDER_CTL = 8'h8e;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned MODE_GATE_SECOND = 7;
	localparam int unsigned MODE_CNT_SECOND = 6;
	localparam int unsigned MODE_SEL_SECOND = 4;
	localparam int unsigned MODE_GATE_FIRST = 3;
	localparam int unsigned MODE_CNT_FIRST = 2;
	localparam int unsigned MODE_SEL_FIRST = 0;
	localparam int unsigned CKD_PRESCALE_SECOND = 4;
	localparam int unsigned CKD_PRESCALE_FIRST = 3;
	localparam int unsigned CTL_OVF_SECOND = 7;
	localparam int unsigned CTL_RUN_SECOND = 6;
	localparam int unsigned CTL_OVF_FIRST = 5;
	localparam int unsigned CTL_RUN_FIRST = 4;
	localparam int unsigned CTL_IRQ_A_FLAG = 1;
	localparam int unsigned CTL_IRQ_A_TYPE = 0;

	// ------------------------------------------------------------
	// modes and time base
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_PRESCALED = 2'h0;
	localparam logic [1:0] MODE_FULL = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam int unsigned DIV_FAST = 4;
	localparam int unsigned DIV_SLOW = 12;

	// ------------------------------------------------------------
	// carriers and state
	// ------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} dtc_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} dtc_wb_rsp_type;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] lvl;
		logic [3:0] div_fast;
		logic [3:0] div_slow;
		logic [7:0] timer_mode_ctl;
		logic [7:0] t0_lo;
		logic [7:0] t0_hi;
		logic [7:0] t1_lo;
		logic [7:0] t1_hi;
		logic prescale_sel_first;
		logic prescale_sel_second;
		logic run_bit_first;
		logic run_bit_second;
		logic ovf_first;
		logic ovf_second;
		logic irq_a_flag;
		logic ext_irq_a_trigger_type;
	} dtc_state_type;
endpackage

// ==== rtl/dtc_top.sv ====
// Function
// - set external irq A flag when the selected edge or level appears on its pin
// - in edge mode, service entry clears the external irq A flag
// - in level mode the flag ignores service entry and tracks the pin
// - trigger-type bit 0 picks falling edge or low level for irq A
// - each timer counts only while its run bit is one
// - gate bit 7 set: timer 1 counts only while pin B high and run set
// - gate bit 3 set: timer 0 counts only while pin A high and run set
// - mode bit 6 picks timer 1 source: time base or count pin falling edges
// - mode bit 2 picks timer 0 source: time base or count pin falling edges
// - mode bits 5:4 give timer 1 mode, bits 1:0 give timer 0 mode
// - mode 0: high byte counts behind a 5-bit low byte prescaler
// - mode 1: high and low bytes form one 16-bit counter
// - mode 2: low byte counts, reloading from the high byte
// - mode 3: timer 0 low byte own controls, high byte timer 1 controls
// - timer 1 in mode 3 stops and holds its count
// - divider bit 3: timer 0 time base divide by 4 when one, else 12
// - divider bit 4: timer 1 time base divide by 4 when one, else 12
// - each count byte readable and writable at its own address
//
// The Wishbone register port was decided locally.
module dtc_top #(
	parameter int unsigned FAST_DIV = dtc_pkg::DIV_FAST,
	parameter int unsigned SLOW_DIV = dtc_pkg::DIV_SLOW
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire dtc_pkg::dtc_wb_req_type wb_req_i,
	output dtc_pkg::dtc_wb_rsp_type wb_rsp_o,
	// pins
	input wire logic ext_irq_pin_a_i,
	input wire logic ext_irq_pin_b_i,
	input wire logic count_pin_first_i,
	input wire logic count_pin_second_i,
	// service and flags
	input wire logic irq_a_service_i,
	output logic ext_irq_a_flag_o,
	output logic timer0_ovf_flag_o,
	output logic timer1_ovf_flag_o
);
	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (FAST_DIV < 1 || FAST_DIV > 16 || SLOW_DIV < 1 || SLOW_DIV > 16) begin : g_bad_div
		$error("divider counts must lie in 1..16");
	end

	localparam logic [3:0] FAST_LAST = 4'(FAST_DIV - 1);
	localparam logic [3:0] SLOW_LAST = 4'(SLOW_DIV - 1);
	localparam int unsigned IDX_LSB_HI = dtc_pkg::IDX_LSB + 7;

	// ------------------------------------------------------------
	// counting step: returns {overflow, high, low}
	// ------------------------------------------------------------
	function automatic logic [16:0] dtc_step(input logic [1:0] mode, input logic [7:0] lo,
		input logic [7:0] hi, input logic inc);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		if (inc) begin
			case (mode)
				dtc_pkg::MODE_PRESCALED: begin
					r[4:0] = lo[4:0] + 5'h01;
					if (lo[4:0] == 5'h1f) begin
						r[15:8] = hi + 8'h01;
						r[16] = (hi == 8'hff);
					end
				end
				dtc_pkg::MODE_FULL: begin
					r[15:0] = {hi, lo} + 16'h0001;
					r[16] = ({hi, lo} == 16'hffff);
				end
				dtc_pkg::MODE_RELOAD: begin
					r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
					r[16] = (lo == 8'hff);
				end
				default: begin
					r[7:0] = lo + 8'h01;
					r[16] = (lo == 8'hff);
				end
			endcase
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	dtc_pkg::dtc_state_type s_r;
	dtc_pkg::dtc_state_type s_nxt;

	logic acc;
	logic hit;
	logic wr;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [7:0] rbyte;
	logic [3:0] fall;
	logic tick_fast;
	logic tick_slow;
	logic base0;
	logic base1;
	logic en0;
	logic en1;
	logic inc0;
	logic inc1;
	logic inc0_hi;
	logic split;
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic [16:0] step0;
	logic [16:0] step1;
	logic [7:0] split_hi;
	logic split_ovf;
	logic ovf0_ev;
	logic ovf1_ev;

	always_comb begin
		s_nxt = s_r;

		// bus decode
		idx = wb_req_i.adr[IDX_LSB_HI:dtc_pkg::IDX_LSB];
		hit = (wb_req_i.adr[31:IDX_LSB_HI + 1] == '0) && (wb_req_i.adr[1:0] == 2'h0)
			&& (idx >= dtc_pkg::IDX_TIMER_IRQ_CTL) && (idx <= dtc_pkg::IDX_CLOCK_DIVIDER_CTL);
		acc = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
		wr = acc & hit & wb_req_i.we & wb_req_i.sel[0];
		wdat = wb_req_i.dat[7:0];

		// pin filters: a change counts once sync2 and sync3 agree
		s_nxt.sync1 = {count_pin_second_i, count_pin_first_i, ext_irq_pin_b_i, ext_irq_pin_a_i};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		s_nxt.lvl = (s_r.sync2 & s_r.sync3) | (s_r.lvl & (s_r.sync2 | s_r.sync3));
		fall = s_r.lvl & ~s_nxt.lvl;

		// time base dividers
		tick_fast = (s_r.div_fast == FAST_LAST);
		tick_slow = (s_r.div_slow == SLOW_LAST);
		s_nxt.div_fast = tick_fast ? 4'h0 : s_r.div_fast + 4'h1;
		s_nxt.div_slow = tick_slow ? 4'h0 : s_r.div_slow + 4'h1;
		base0 = s_r.prescale_sel_first ? tick_fast : tick_slow;
		base1 = s_r.prescale_sel_second ? tick_fast : tick_slow;

		// enables and sources
		mode0 = s_r.timer_mode_ctl[dtc_pkg::MODE_SEL_FIRST +: 2];
		mode1 = s_r.timer_mode_ctl[dtc_pkg::MODE_SEL_SECOND +: 2];
		split = (mode0 == dtc_pkg::MODE_SPLIT);
		en0 = s_r.run_bit_first & (~s_r.timer_mode_ctl[dtc_pkg::MODE_GATE_FIRST] | s_r.lvl[0]);
		en1 = s_r.run_bit_second & (~s_r.timer_mode_ctl[dtc_pkg::MODE_GATE_SECOND] | s_r.lvl[1]);
		inc0 = en0 & (s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_FIRST] ? fall[2] : base0);
		inc1 = en1 & (s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_SECOND] ? fall[3] : base1)
			& (mode1 != dtc_pkg::MODE_SPLIT);
		inc0_hi = split & s_r.run_bit_second & base1;

		// counting
		step0 = dtc_step(mode0, s_r.t0_lo, s_r.t0_hi, inc0);
		step1 = dtc_step(mode1, s_r.t1_lo, s_r.t1_hi, inc1);
		split_hi = inc0_hi ? s_r.t0_hi + 8'h01 : s_r.t0_hi;
		split_ovf = inc0_hi & (s_r.t0_hi == 8'hff);
		ovf0_ev = step0[16];
		ovf1_ev = split ? split_ovf : step1[16];
		s_nxt.t0_lo = step0[7:0];
		s_nxt.t0_hi = split ? split_hi : step0[15:8];
		s_nxt.t1_lo = step1[7:0];
		s_nxt.t1_hi = step1[15:8];

		// software writes to counts and setup
		if (wr) begin
			case (idx)
				dtc_pkg::IDX_TIMER_MODE_CTL: s_nxt.timer_mode_ctl = wdat;
				dtc_pkg::IDX_TIMER0_COUNT_LOW: s_nxt.t0_lo = wdat;
				dtc_pkg::IDX_TIMER1_COUNT_LOW: s_nxt.t1_lo = wdat;
				dtc_pkg::IDX_TIMER0_COUNT_HIGH: s_nxt.t0_hi = wdat;
				dtc_pkg::IDX_TIMER1_COUNT_HIGH: s_nxt.t1_hi = wdat;
				dtc_pkg::IDX_CLOCK_DIVIDER_CTL: begin
					s_nxt.prescale_sel_first = wdat[dtc_pkg::CKD_PRESCALE_FIRST];
					s_nxt.prescale_sel_second = wdat[dtc_pkg::CKD_PRESCALE_SECOND];
				end
				dtc_pkg::IDX_TIMER_IRQ_CTL: begin
					s_nxt.run_bit_first = wdat[dtc_pkg::CTL_RUN_FIRST];
					s_nxt.run_bit_second = wdat[dtc_pkg::CTL_RUN_SECOND];
					s_nxt.ovf_first = wdat[dtc_pkg::CTL_OVF_FIRST];
					s_nxt.ovf_second = wdat[dtc_pkg::CTL_OVF_SECOND];
					s_nxt.irq_a_flag = wdat[dtc_pkg::CTL_IRQ_A_FLAG];
					s_nxt.ext_irq_a_trigger_type = wdat[dtc_pkg::CTL_IRQ_A_TYPE];
				end
				default: s_nxt.t1_hi = s_nxt.t1_hi;
			endcase
		end

		// overflow flags: hardware set wins over software clear
		if (ovf0_ev) begin
			s_nxt.ovf_first = 1'b1;
		end
		if (ovf1_ev) begin
			s_nxt.ovf_second = 1'b1;
		end

		// external irq A flag
		if (s_r.ext_irq_a_trigger_type) begin
			if (fall[0]) begin
				s_nxt.irq_a_flag = 1'b1;
			end else if (irq_a_service_i && !(wr && idx == dtc_pkg::IDX_TIMER_IRQ_CTL)) begin
				s_nxt.irq_a_flag = 1'b0;
			end
		end else begin
			s_nxt.irq_a_flag = ~s_r.lvl[0];
		end

		// read data
		case (idx)
			dtc_pkg::IDX_TIMER_IRQ_CTL: rbyte = {s_r.ovf_second, s_r.run_bit_second, s_r.ovf_first,
				s_r.run_bit_first, 2'h0, s_r.irq_a_flag, s_r.ext_irq_a_trigger_type};
			dtc_pkg::IDX_TIMER_MODE_CTL: rbyte = s_r.timer_mode_ctl;
			dtc_pkg::IDX_TIMER0_COUNT_LOW: rbyte = s_r.t0_lo;
			dtc_pkg::IDX_TIMER1_COUNT_LOW: rbyte = s_r.t1_lo;
			dtc_pkg::IDX_TIMER0_COUNT_HIGH: rbyte = s_r.t0_hi;
			dtc_pkg::IDX_TIMER1_COUNT_HIGH: rbyte = s_r.t1_hi;
			dtc_pkg::IDX_CLOCK_DIVIDER_CTL: rbyte = {3'h0, s_r.prescale_sel_second,
				s_r.prescale_sel_first, 3'h0};
			default: rbyte = 8'h00;
		endcase
		s_nxt.ack = acc;
		s_nxt.rdat = (acc && hit && !wb_req_i.we) ? {24'h000000, rbyte} : 32'h00000000;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.timer_mode_ctl <= dtc_pkg::RST_BYTE;
			s_r.t0_lo <= dtc_pkg::RST_BYTE;
			s_r.t0_hi <= dtc_pkg::RST_BYTE;
			s_r.t1_lo <= dtc_pkg::RST_BYTE;
			s_r.t1_hi <= dtc_pkg::RST_BYTE;
			s_r.lvl <= 4'hf;
			s_r.sync1 <= 4'hf;
			s_r.sync2 <= 4'hf;
			s_r.sync3 <= 4'hf;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign wb_rsp_o.ack = s_r.ack;
	assign wb_rsp_o.dat = s_r.rdat;
	assign ext_irq_a_flag_o = s_r.irq_a_flag;
	assign timer0_ovf_flag_o = s_r.ovf_first;
	assign timer1_ovf_flag_o = s_r.ovf_second;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic wr_any;
	assign wr_any = wr;

	bus_ack_a: assert property (acc |=> s_r.ack ##1 !s_r.ack)
		else $error("ack not a single cycle after request");
	idle_data_a: assert property (!s_r.ack |-> s_r.rdat == 32'h00000000)
		else $error("read data not zero between answers");
	mode_write_a: assert property (wr && idx == dtc_pkg::IDX_TIMER_MODE_CTL
		|=> s_r.timer_mode_ctl == $past(wdat))
		else $error("mode register write lost");
	run_hold_a: assert property (!s_r.run_bit_first && !wr_any && mode0 == dtc_pkg::MODE_FULL
		|=> {s_r.t0_lo, s_r.t0_hi} == $past({s_r.t0_lo, s_r.t0_hi}))
		else $error("timer 0 moved while stopped");
	gate_first_a: assert property (s_r.timer_mode_ctl[dtc_pkg::MODE_GATE_FIRST] && !s_r.lvl[0]
		&& !wr_any && mode0 == dtc_pkg::MODE_FULL |=> $stable(s_r.t0_lo))
		else $error("timer 0 counted with gate low");
	gate_second_a: assert property (s_r.timer_mode_ctl[dtc_pkg::MODE_GATE_SECOND] && !s_r.lvl[1]
		&& !wr_any |=> $stable(s_r.t1_lo) && $stable(s_r.t1_hi))
		else $error("timer 1 counted with gate low");
	split_stop_a: assert property (mode1 == dtc_pkg::MODE_SPLIT && !wr_any
		|=> $stable({s_r.t1_lo, s_r.t1_hi}))
		else $error("timer 1 moved in mode 3");
	reload_low_a: assert property (ovf0_ev && mode0 == dtc_pkg::MODE_RELOAD && !wr_any
		|=> s_r.t0_lo == $past(s_r.t0_hi) && s_r.ovf_first)
		else $error("mode 2 reload missing");
	ovf_flag_a: assert property (ovf1_ev |=> s_r.ovf_second)
		else $error("overflow flag not set");
	level_track_a: assert property (!s_r.ext_irq_a_trigger_type |=> s_r.irq_a_flag == !$past(s_r.lvl[0]))
		else $error("level flag does not follow pin");
	edge_clear_a: assert property (s_r.ext_irq_a_trigger_type && irq_a_service_i && !fall[0]
		&& !wr_any |=> !s_r.irq_a_flag)
		else $error("edge flag not cleared on service");
	slow_base_a: assert property (tick_slow |=> !tick_slow [*8])
		else $error("slow time base too fast");
	fast_base_a: assert property (tick_fast |-> ##4 tick_fast)
		else $error("fast time base period wrong");

	// ------------------------------------------------------------
	// counting paths
	// ------------------------------------------------------------
	full_carry_a: assert property (inc0 && mode0 == dtc_pkg::MODE_FULL && s_r.t0_lo == 8'hff && !wr_any
		|=> s_r.t0_hi == $past(s_r.t0_hi) + 8'h01 && s_r.t0_lo == 8'h00)
		else $error("16-bit carry missing");
	prescale_top_a: assert property (inc0 && mode0 == dtc_pkg::MODE_PRESCALED && !wr_any
		|=> s_r.t0_lo[7:5] == $past(s_r.t0_lo[7:5]))
		else $error("prescaler touched upper low-byte bits");
	first_src_a: assert property (en0 && s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_FIRST] && !fall[2]
		&& mode0 == dtc_pkg::MODE_FULL && !wr_any |=> $stable({s_r.t0_hi, s_r.t0_lo}))
		else $error("timer 0 counted without a pin edge");
	second_src_a: assert property (en1 && s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_SECOND] && !fall[3]
		&& mode1 == dtc_pkg::MODE_FULL && !wr_any |=> $stable({s_r.t1_hi, s_r.t1_lo}))
		else $error("timer 1 counted without a pin edge");
	first_base_a: assert property (en0 && !s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_FIRST] && !tick_fast
		&& s_r.prescale_sel_first && mode0 == dtc_pkg::MODE_FULL && !wr_any |=> $stable({s_r.t0_hi, s_r.t0_lo}))
		else $error("timer 0 counted off its time base");
	second_base_a: assert property (en1 && !s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_SECOND] && !tick_fast
		&& s_r.prescale_sel_second && mode1 == dtc_pkg::MODE_FULL && !wr_any |=> $stable({s_r.t1_hi, s_r.t1_lo}))
		else $error("timer 1 counted off its time base");
	reload_high_a: assert property (ovf1_ev && !split && mode1 == dtc_pkg::MODE_RELOAD && !wr_any
		|=> s_r.t1_lo == $past(s_r.t1_hi))
		else $error("timer 1 reload missing");
	split_high_a: assert property (split && inc0_hi && !wr_any
		|=> s_r.t0_hi == $past(s_r.t0_hi) + 8'h01)
		else $error("split high byte did not count");
	second_hold_a: assert property (!s_r.run_bit_second && !wr_any
		|=> $stable({s_r.t1_hi, s_r.t1_lo}))
		else $error("timer 1 moved while stopped");
	ovf_first_a: assert property (ovf0_ev |=> s_r.ovf_first)
		else $error("timer 0 overflow flag not set");

	// ------------------------------------------------------------
	// interrupt pin and filter
	// ------------------------------------------------------------
	edge_set_a: assert property (s_r.ext_irq_a_trigger_type && fall[0] |=> s_r.irq_a_flag)
		else $error("edge flag not set on falling edge");
	filter_track_a: assert property (s_r.sync2 == s_r.sync3 |=> s_r.lvl == $past(s_r.sync3))
		else $error("pin filter did not follow agreeing samples");

	split_cov_c: cover property (split && inc0_hi ##1 s_r.ovf_second);
	reload_cov_c: cover property (ovf0_ev && mode0 == dtc_pkg::MODE_RELOAD);
	edge_cov_c: cover property (fall[0] && s_r.ext_irq_a_trigger_type ##[1:20] irq_a_service_i);
	count_cov_c: cover property (inc1 && s_r.timer_mode_ctl[dtc_pkg::MODE_CNT_SECOND]);
	pin_count_c: cover property (inc0 && fall[2]);
endmodule

// ==== tb/dtc_pin_model.sv ====
module dtc_pin_model (
	// clock
	input wire logic clk_i,
	// pins toward the block
	output logic pin_a_o,
	output logic pin_b_o,
	output logic cnt_first_o,
	output logic cnt_second_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// idle pins rest high, as if pulled up
	// ------------------------------------------------------------
	initial begin
		pin_a_o = 1'b1;
		pin_b_o = 1'b1;
		cnt_first_o = 1'b1;
		cnt_second_o = 1'b1;
	end

	task automatic set_gate(input logic a, input logic b);
		@(posedge clk_i);
		pin_a_o <= a;
		pin_b_o <= b;
	endtask

	// ------------------------------------------------------------
	// falling edges, each phase well above the filter length
	// ------------------------------------------------------------
	task automatic pulse(input logic ch, input int n);
		repeat (n) begin
			@(posedge clk_i);
			if (ch) cnt_second_o <= 1'b0;
			else cnt_first_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			if (ch) cnt_second_o <= 1'b1;
			else cnt_first_o <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] ctl = dtc_pkg::IDX_TIMER_IRQ_CTL;
	localparam logic [7:0] mdc = dtc_pkg::IDX_TIMER_MODE_CTL;
	localparam logic [7:0] c0l = dtc_pkg::IDX_TIMER0_COUNT_LOW;
	localparam logic [7:0] c1l = dtc_pkg::IDX_TIMER1_COUNT_LOW;
	localparam logic [7:0] c0h = dtc_pkg::IDX_TIMER0_COUNT_HIGH;
	localparam logic [7:0] c1h = dtc_pkg::IDX_TIMER1_COUNT_HIGH;
	localparam logic [7:0] ckd = dtc_pkg::IDX_CLOCK_DIVIDER_CTL;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic svc = 1'b0;
	dtc_pkg::dtc_wb_req_type wb_req = '0;
	dtc_pkg::dtc_wb_rsp_type wb_rsp;
	logic pin_a, pin_b, cnt_first, cnt_second, irq_flag, ovf0, ovf1;
	logic [7:0] rv;
	logic [31:0] rd;
	logic [7:0] cnt_idx [4];
	int fail_count = 0;
	int checks_done = 0;

	always #4 clk_i = ~clk_i;

	dtc_pin_model pm (.clk_i(clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b), .cnt_first_o(cnt_first),
		.cnt_second_o(cnt_second));

	dtc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
		.ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b), .count_pin_first_i(cnt_first),
		.count_pin_second_i(cnt_second), .irq_a_service_i(svc), .ext_irq_a_flag_o(irq_flag),
		.timer0_ovf_flag_o(ovf0), .timer1_ovf_flag_o(ovf1));

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		checks_done++;
		if (!(got >= lo && got <= hi) || $isunknown(got)) begin
			fail_count++;
			$display("BAD %s expected %0d..%0d seen %h", nm, lo, hi, got);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		int i;
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {22'h0, idx, 2'h0}, sel: 4'h1, dat: {24'h0, wd}};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_rsp.ack === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			wrap_up();
		end else begin
			rd = wb_rsp.dat;
			wb_req <= '0;
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		wb(1'b1, idx, wd);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, exp}, rd);
	endtask

	task automatic serve();
		@(posedge clk_i);
		svc <= 1'b1;
		@(posedge clk_i);
		svc <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rv = 8'($urandom(32'hfa91));
		cnt_idx = '{c0l, c1l, c0h, c1h};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		for (int k = 0; k < 7; k++) rd_chk("reset value", ctl + 8'(k), 8'h00);
		rd_chk("unmapped", 8'h90, 8'h00);
		for (int k = 0; k < 4; k++) begin
			rv = 8'($urandom);
			wr(cnt_idx[k], rv);
			rd_chk("count byte", cnt_idx[k], rv);
		end
		rv = 8'($urandom);
		wr(mdc, rv);
		rd_chk("mode ctl", mdc, rv);
		wr(ckd, rv);
		rd_chk("divider", ckd, rv & 8'h18);
		// 16-bit wrap on pin edges, timer 1 held without its run bit
		wr(mdc, 8'h65);
		wr(c0l, 8'hfe);
		wr(c0h, 8'hff);
		wr(c1l, 8'h00);
		wr(ctl, 8'h10);
		pm.pulse(1'b0, 3);
		pm.pulse(1'b1, 2);
		rd_chk("t0 low wrap", c0l, 8'h01);
		rd_chk("t0 high wrap", c0h, 8'h00);
		chk("t0 overflow", 32'h1, ovf0);
		rd_chk("t1 stopped", c1l, 8'h00);
		// auto reload
		wr(c1h, 8'hf0);
		wr(c1l, 8'hfe);
		wr(ctl, 8'h50);
		pm.pulse(1'b1, 3);
		rd_chk("t1 reload", c1l, 8'hf1);
		chk("t1 overflow", 32'h1, ovf1);
		// gating by the interrupt pins
		wr(mdc, 8'hdd);
		wr(c0l, 8'h00);
		wr(c1l, 8'h00);
		pm.set_gate(1'b0, 1'b0);
		pm.pulse(1'b0, 2);
		pm.pulse(1'b1, 2);
		rd_chk("t0 gated off", c0l, 8'h00);
		rd_chk("t1 gated off", c1l, 8'h00);
		pm.set_gate(1'b1, 1'b1);
		pm.pulse(1'b0, 2);
		pm.pulse(1'b1, 2);
		rd_chk("t0 gated on", c0l, 8'h02);
		rd_chk("t1 gated on", c1l, 8'h02);
		// prescaled mode
		wr(mdc, 8'h04);
		wr(c0l, 8'hff);
		wr(c0h, 8'h05);
		wr(ctl, 8'h10);
		pm.pulse(1'b0, 1);
		rd_chk("prescale low", c0l, 8'he0);
		rd_chk("prescale high", c0h, 8'h06);
		// timer 0 auto reload on pin edges
		wr(mdc, 8'h06);
		wr(c0h, 8'h80);
		wr(c0l, 8'hff);
		wr(ctl, 8'h10);
		pm.pulse(1'b0, 2);
		rd_chk("t0 reload", c0l, 8'h81);
		rd_chk("t0 reload source", c0h, 8'h80);
		chk("t0 reload overflow", 32'h1, ovf0);
		// split mode, high byte on the fast timer 1 time base
		wr(mdc, 8'h77);
		wr(ckd, 8'h10);
		wr(c0l, 8'h00);
		wr(c0h, 8'h00);
		wr(c1l, 8'h33);
		wr(ctl, 8'h50);
		pm.pulse(1'b0, 2);
		pm.pulse(1'b1, 2);
		rd_chk("split low", c0l, 8'h02);
		rd_chk("t1 split held", c1l, 8'h33);
		wr(ctl, 8'h00);
		wb(1'b0, c0h, 8'h00);
		chk_rng("split high", 10, 13, rd);
		// internal time base, both divider settings
		for (int k = 0; k < 2; k++) begin
			wr(ctl, 8'h00);
			wr(mdc, 8'h11);
			wr(ckd, k ? 8'h10 : 8'h08);
			for (int j = 0; j < 4; j++) wr(cnt_idx[j], 8'h00);
			wr(ctl, 8'h50);
			repeat (240) @(posedge clk_i);
			wr(ctl, 8'h00);
			wb(1'b0, c0l, 8'h00);
			chk_rng("t0 time base", k ? 18 : 58, k ? 22 : 63, rd);
			wb(1'b0, c1l, 8'h00);
			chk_rng("t1 time base", k ? 58 : 18, k ? 63 : 22, rd);
		end
		// interrupt A, edge then level
		wr(mdc, 8'h00);
		wr(ctl, 8'h01);
		pm.set_gate(1'b0, 1'b1);
		settle();
		chk("edge flag set", 32'h1, irq_flag);
		pm.set_gate(1'b1, 1'b1);
		settle();
		chk("edge flag stays", 32'h1, irq_flag);
		serve();
		chk("edge flag served", 32'h0, irq_flag);
		wr(ctl, 8'h00);
		pm.set_gate(1'b0, 1'b1);
		settle();
		chk("level flag set", 32'h1, irq_flag);
		serve();
		chk("level flag kept", 32'h1, irq_flag);
		pm.set_gate(1'b1, 1'b1);
		settle();
		chk("level flag tracks", 32'h0, irq_flag);
		wrap_up();
	end
endmodule
